// ==== hw/bfm_top.sv ====
// Brake feedback monitor: APB registers, trip sequencing and latched lift stop
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bfm_regs.svh"
module bfm_top (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [`BFM_ADDR_W-1:0] i_paddr,
   input wire bfm_pkg::bfm_word_t i_pwdata,
   output bfm_pkg::bfm_word_t o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire bfm_pkg::bfm_in_t i_fb,
   input wire logic i_drive_cmd,
   input wire logic i_brake_open_cmd,
   input wire logic i_brake_close_cmd,
   input wire logic i_nv_fault,
   output logic o_nv_fault,
   output logic o_lift_stop
);
   import bfm_pkg::*;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic bfm_in_t brake_open_of(input bfm_in_t fb, input bfm_in_t pol);
      brake_open_of = fb ^ pol;
   endfunction

   function automatic logic addr_hit(input logic [`BFM_ADDR_W-1:0] a);
      addr_hit = (a == `BFM_OFS_CTRL) || (a == `BFM_OFS_CFG) ||
                 (a == `BFM_OFS_OPEN_TMO) || (a == `BFM_OFS_CLOSE_TMO) ||
                 (a == `BFM_OFS_STATUS);
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic en_reg;
   logic [`BFM_CFG_BITS-1:0] cfg_reg;
   bfm_word_t open_tmo_reg;
   bfm_word_t close_tmo_reg;
   bfm_word_t prdata_reg;
   logic slverr_reg;
   logic unlock_pulse;
   logic wr_en;
   logic setup;
   bfm_in_t sup;
   bfm_in_t pol;
   bfm_in_t open_now;
   bfm_state_t state_reg;
   bfm_state_t state_next;
   bfm_in_t base_reg;
   bfm_in_t chg_reg;
   bfm_in_t chg_now;
   bfm_in_t cause_in_reg;
   logic [1:0] cause_reg;
   logic fault_reg;
   logic restored_reg;
   logic tmr_start;
   logic tmr_stop;
   logic tmr_expired;
   bfm_word_t tmr_limit;
   bfm_in_t hit_drive;
   bfm_in_t hit_tmo;
   logic set_drive;
   logic set_tmo;
   logic fault_set;
   bfm_word_t status;

   assign sup = cfg_reg[`BFM_CFG_SUP_LSB +: `BFM_NUM_IN];
   assign pol = cfg_reg[`BFM_CFG_POL_LSB +: `BFM_NUM_IN];
   assign open_now = brake_open_of(i_fb, pol);

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   assign setup = i_psel && !i_penable;
   assign wr_en = i_psel && i_penable && i_pwrite && addr_hit(i_paddr);
   assign unlock_pulse = wr_en && (i_paddr == `BFM_OFS_CTRL) &&
                         i_pwdata[`BFM_CTRL_UNLOCK_BIT];
   assign o_pready = 1'b1;
   assign o_prdata = prdata_reg;
   assign o_pslverr = i_psel && i_penable && slverr_reg;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         en_reg <= 1'b0;
         cfg_reg <= `BFM_RST_CFG;
         open_tmo_reg <= `BFM_RST_OPEN_TMO;
         close_tmo_reg <= `BFM_RST_CLOSE_TMO;
      end else if (wr_en) begin
         case (i_paddr)
            `BFM_OFS_CTRL: begin
               en_reg <= i_pwdata[`BFM_CTRL_EN_BIT];
            end
            `BFM_OFS_CFG: begin
               cfg_reg <= i_pwdata[`BFM_CFG_BITS-1:0];
            end
            `BFM_OFS_OPEN_TMO: begin
               open_tmo_reg <= i_pwdata;
            end
            `BFM_OFS_CLOSE_TMO: begin
               close_tmo_reg <= i_pwdata;
            end
            default: begin
               en_reg <= en_reg;
            end
         endcase
      end
   end

   always_comb begin
      status = 32'h0000_0000;
      status[`BFM_ST_FAULT_BIT] = fault_reg;
      status[`BFM_ST_NV_BIT] = restored_reg;
      status[`BFM_ST_CAUSE_LSB +: 2] = cause_reg;
      status[`BFM_ST_OPEN_LSB +: `BFM_NUM_IN] = open_now;
      status[`BFM_ST_STATE_LSB +: 4] = state_reg;
      status[`BFM_ST_CHG_LSB +: `BFM_NUM_IN] = cause_in_reg;
   end

   // Read data captured in the setup cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prdata_reg <= 32'h0000_0000;
         slverr_reg <= 1'b0;
      end else if (setup) begin
         slverr_reg <= !addr_hit(i_paddr);
         case (i_paddr)
            `BFM_OFS_CTRL: begin
               prdata_reg <= {31'h0000_0000, en_reg};
            end
            `BFM_OFS_CFG: begin
               prdata_reg <= {24'h00_0000, cfg_reg};
            end
            `BFM_OFS_OPEN_TMO: begin
               prdata_reg <= open_tmo_reg;
            end
            `BFM_OFS_CLOSE_TMO: begin
               prdata_reg <= close_tmo_reg;
            end
            `BFM_OFS_STATUS: begin
               prdata_reg <= status;
            end
            default: begin
               prdata_reg <= 32'h0000_0000;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Trip sequencing
   // ------------------------------------------------------------
   assign chg_now = chg_reg | (i_fb ^ base_reg);

   always_comb begin
      state_next = state_reg;
      tmr_start = 1'b0;
      tmr_stop = 1'b0;
      tmr_limit = open_tmo_reg;
      case (state_reg)
         BFM_IDLE, BFM_OPENED: begin
            if (i_brake_open_cmd) begin
               state_next = BFM_WAIT_OPEN;
               tmr_start = 1'b1;
            end else if (i_brake_close_cmd) begin
               state_next = BFM_WAIT_CLOSE;
               tmr_start = 1'b1;
               tmr_limit = close_tmo_reg;
            end
         end
         BFM_WAIT_OPEN: begin
            if (i_brake_close_cmd) begin
               state_next = BFM_WAIT_CLOSE;
               tmr_start = 1'b1;
               tmr_limit = close_tmo_reg;
            end else if (i_brake_open_cmd) begin
               tmr_start = 1'b1;
            end else if ((chg_now & sup) == sup) begin
               state_next = BFM_OPENED;
               tmr_stop = 1'b1;
            end else if (tmr_expired) begin
               state_next = BFM_OPENED;
            end
         end
         BFM_WAIT_CLOSE: begin
            if (i_brake_open_cmd) begin
               state_next = BFM_WAIT_OPEN;
               tmr_start = 1'b1;
            end else if (i_brake_close_cmd) begin
               tmr_start = 1'b1;
               tmr_limit = close_tmo_reg;
            end else if ((chg_now & sup) == sup) begin
               state_next = BFM_IDLE;
               tmr_stop = 1'b1;
            end else if (tmr_expired) begin
               state_next = BFM_IDLE;
            end
         end
         default: begin
            state_next = BFM_IDLE;
         end
      endcase
      if (!en_reg) begin
         state_next = BFM_IDLE;
         tmr_stop = 1'b1;
         tmr_start = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= BFM_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Feedback baseline taken at each brake command while monitoring is enabled
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         base_reg <= 4'h0;
         chg_reg <= 4'h0;
      end else if (tmr_start) begin
         base_reg <= i_fb;
         chg_reg <= 4'h0;
      end else begin
         chg_reg <= chg_now;
      end
   end

   bfm_timer u_timer (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_start(tmr_start),
      .i_stop(tmr_stop),
      .i_limit(tmr_limit),
      .o_expired(tmr_expired)
   );

   // ------------------------------------------------------------
   // Fault detection and latch
   // ------------------------------------------------------------
   assign hit_drive = (i_drive_cmd && en_reg) ? (open_now & sup) : 4'h0;
   assign hit_tmo = (tmr_expired && !tmr_start && en_reg &&
                     (state_reg == BFM_WAIT_OPEN || state_reg == BFM_WAIT_CLOSE)) ?
                    (sup & ~chg_now) : 4'h0;
   assign set_drive = |hit_drive;
   assign set_tmo = |hit_tmo;
   assign fault_set = set_drive || set_tmo;

   // Stored fault restored once after reset; set wins over unlock
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fault_reg <= 1'b0;
         restored_reg <= 1'b0;
      end else begin
         restored_reg <= 1'b1;
         if (!restored_reg) begin
            fault_reg <= i_nv_fault;
         end else if (fault_set) begin
            fault_reg <= 1'b1;
         end else if (unlock_pulse) begin
            fault_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cause_reg <= 2'h0;
         cause_in_reg <= 4'h0;
      end else if (fault_set && !fault_reg) begin
         cause_in_reg <= hit_drive | hit_tmo;
         if (set_drive) begin
            cause_reg <= `BFM_CAUSE_DRIVE;
         end else if (state_reg == BFM_WAIT_OPEN) begin
            cause_reg <= `BFM_CAUSE_OPEN;
         end else begin
            cause_reg <= `BFM_CAUSE_CLOSE;
         end
      end else if (unlock_pulse && restored_reg && !fault_set) begin
         cause_reg <= 2'h0;
         cause_in_reg <= 4'h0;
      end
   end

   assign o_lift_stop = fault_reg;
   assign o_nv_fault = fault_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_drive_open;
      en_reg && i_drive_cmd && |(open_now & sup);
   endsequence

   sequence s_open_timeout;
      en_reg && state_reg == BFM_WAIT_OPEN && tmr_expired && !tmr_start &&
      |(sup & ~chg_now);
   endsequence

   sequence s_close_timeout;
      en_reg && state_reg == BFM_WAIT_CLOSE && tmr_expired && !tmr_start &&
      |(sup & ~chg_now);
   endsequence

   AST_DRIVE_OPEN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      restored_reg and s_drive_open |=> fault_reg && o_lift_stop)
      else $error("open brake at drive command not flagged");

   AST_OPEN_TMO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      restored_reg and s_open_timeout |=> fault_reg ##0 state_reg == BFM_OPENED)
      else $error("open timeout without feedback change not flagged");

   AST_CLOSE_TMO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      restored_reg and s_close_timeout |=> fault_reg ##0 state_reg == BFM_IDLE)
      else $error("close timeout without feedback change not flagged");

   AST_DISABLED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      restored_reg && !en_reg && !fault_reg |=> !fault_reg)
      else $error("fault raised while monitoring is off");

   AST_UNUSED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      restored_reg && sup == 4'h0 && !fault_reg |=> !fault_reg)
      else $error("fault raised with no supervised input");

   AST_LATCH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      restored_reg && fault_reg && !unlock_pulse |=>
      fault_reg ##1 (fault_reg || $past(unlock_pulse)))
      else $error("latched fault released without unlock");

   AST_UNLOCK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      restored_reg && $fell(fault_reg) |-> $past(unlock_pulse) && !$past(fault_set))
      else $error("fault cleared by something other than unlock");

   AST_RESTORE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !restored_reg && i_nv_fault |=> o_lift_stop && o_nv_fault)
      else $error("stored fault not restored after reset");

   AST_TAMPER: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      fault_set && unlock_pulse && restored_reg |=> fault_reg)
      else $error("detection lost to a simultaneous unlock");
endmodule
`default_nettype wire

// ==== hw/bfm_regs.svh ====
// Register map, field positions, reset values and timing for the brake feedback monitor
`ifndef BFM_REGS_SVH
`define BFM_REGS_SVH

`define BFM_NUM_IN 4
`define BFM_ADDR_W 8

`define BFM_OFS_CTRL 8'h00
`define BFM_OFS_CFG 8'h04
`define BFM_OFS_OPEN_TMO 8'h08
`define BFM_OFS_CLOSE_TMO 8'h0C
`define BFM_OFS_STATUS 8'h10

`define BFM_CTRL_EN_BIT 0
`define BFM_CTRL_UNLOCK_BIT 1
`define BFM_CFG_SUP_LSB 0
`define BFM_CFG_POL_LSB 4
`define BFM_CFG_BITS 8

`define BFM_ST_FAULT_BIT 0
`define BFM_ST_NV_BIT 1
`define BFM_ST_CAUSE_LSB 4
`define BFM_ST_OPEN_LSB 8
`define BFM_ST_STATE_LSB 12
`define BFM_ST_CHG_LSB 16

`define BFM_CAUSE_DRIVE 2'h1
`define BFM_CAUSE_OPEN 2'h2
`define BFM_CAUSE_CLOSE 2'h3

`define BFM_RST_CFG 8'h00
`define BFM_RST_OPEN_TMO 32'h000F_4240
`define BFM_RST_CLOSE_TMO 32'h000F_4240

`endif

// ==== hw/bfm_pkg.sv ====
// Types shared by the brake feedback monitor files
package bfm_pkg;
   typedef enum logic [3:0] {
      BFM_IDLE       = 4'h1,
      BFM_WAIT_OPEN  = 4'h2,
      BFM_OPENED     = 4'h4,
      BFM_WAIT_CLOSE = 4'h8
   } bfm_state_t;
   typedef logic [3:0] bfm_in_t;
   typedef logic [31:0] bfm_word_t;
endpackage

// ==== hw/bfm_timer.sv ====
// Restartable timeout counter for the brake feedback monitor
`timescale 1ns/1ps
`default_nettype none
module bfm_timer (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic i_stop,
   input wire bfm_pkg::bfm_word_t i_limit,
   output logic o_expired
);
   import bfm_pkg::*;

   bfm_word_t cnt_reg;
   logic run_reg;

   // ------------------------------------------------------------
   // Countdown
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg <= 32'h0000_0000;
         run_reg <= 1'b0;
      end else if (i_start) begin
         cnt_reg <= i_limit;
         run_reg <= 1'b1;
      end else if (i_stop || o_expired) begin
         run_reg <= 1'b0;
      end else if (run_reg) begin
         cnt_reg <= cnt_reg - 32'h0000_0001;
      end
   end

   assign o_expired = run_reg && (cnt_reg == 32'h0000_0000);

   AST_TMR_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_start && i_limit == 32'h0000_0000) |=> o_expired)
      else $error("timer with zero limit did not expire next cycle");
endmodule
`default_nettype wire

// ==== sim/bfm_brake_model.sv ====
// Brake armature and feedback contacts model
`timescale 1ns/1ps
`default_nettype none
module bfm_brake_model (
   input wire logic i_clk,
   input wire logic i_open_cmd,
   input wire logic i_close_cmd,
   input wire logic [3:0] i_pol,
   input wire logic [3:0] i_stuck,
   input wire logic [3:0] i_delay,
   output logic [3:0] o_fb
);
   logic open_reg = 1'b0;
   logic pend_reg = 1'b0;
   logic tgt_reg = 1'b0;
   logic [3:0] cnt_reg = 4'h0;
   logic [3:0] fb_reg = 4'h0;
   // -------------------------
   // Armature follows command after delay
   // -------------------------
   always_ff @(posedge i_clk) begin
      if (i_open_cmd || i_close_cmd) begin
         pend_reg <= 1'b1;
         tgt_reg <= i_open_cmd;
         cnt_reg <= i_delay;
      end else if (pend_reg && cnt_reg == 4'h0) begin
         open_reg <= tgt_reg;
         pend_reg <= 1'b0;
      end else if (pend_reg) begin
         cnt_reg <= cnt_reg - 4'h1;
      end
   end
   // -------------------------
   // Contacts, stuck ones frozen
   // -------------------------
   always_ff @(posedge i_clk) begin
      for (int i = 0; i < 4; i++) begin
         fb_reg[i] <= i_stuck[i] ? fb_reg[i] : (open_reg ^ i_pol[i]);
      end
   end
   assign o_fb = fb_reg;
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the brake feedback monitor
`timescale 1ns/1ps
`default_nettype none
`include "bfm_regs.svh"
module testbench;
   import bfm_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   bfm_word_t pwdata = 32'h0;
   bfm_word_t prdata;
   logic pready;
   logic pslverr;
   bfm_in_t fb;
   logic [2:0] cmd = 3'h0;
   logic nv_in = 1'b0;
   logic nv_out;
   logic stop;
   logic [3:0] stuck = 4'h0;
   bfm_word_t q;
   logic err;
   int n_fail = 0;
   int tests_run = 0;

   always #50 i_clk = ~i_clk;

   bfm_top u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_fb(fb), .i_drive_cmd(cmd[2]),
      .i_brake_open_cmd(cmd[1]), .i_brake_close_cmd(cmd[0]), .i_nv_fault(nv_in),
      .o_nv_fault(nv_out), .o_lift_stop(stop));
   bfm_brake_model u_brake (.i_clk(i_clk), .i_open_cmd(cmd[1]), .i_close_cmd(cmd[0]),
      .i_pol(4'h2), .i_stuck(stuck), .i_delay(4'h2), .o_fb(fb));

   // -------------------------
   // Shared tasks
   // -------------------------
   task report_and_stop;
      $display("Checks run %0d, failed %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task chk(input string nm, input bfm_word_t exp, input bfm_word_t got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task apb(input logic wr, input logic [7:0] a, input bfm_word_t d);
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      do @(posedge i_clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task pulse(input int k);
      @(posedge i_clk);
      cmd[k] <= 1'b1;
      @(posedge i_clk);
      cmd[k] <= 1'b0;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // -------------------------
   // Scenarios
   // -------------------------
   task s_regs;
      apb(1'b0, `BFM_OFS_CFG, 32'h0);
      chk("cfg reset", 32'(`BFM_RST_CFG), q);
      apb(1'b0, `BFM_OFS_OPEN_TMO, 32'h0);
      chk("open tmo reset", `BFM_RST_OPEN_TMO, q);
      apb(1'b0, `BFM_OFS_CLOSE_TMO, 32'h0);
      chk("close tmo reset", `BFM_RST_CLOSE_TMO, q);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped err", 32'h1, 32'(err));
      apb(1'b1, `BFM_OFS_OPEN_TMO, 32'h5);
      apb(1'b1, `BFM_OFS_CLOSE_TMO, 32'h5);
      apb(1'b1, `BFM_OFS_CFG, 32'h23);
   endtask

   task s_disabled;
      stuck <= 4'h3;
      pulse(1);
      cyc(10);
      stuck <= 4'h0;
      cyc(4);
      pulse(2);
      pulse(0);
      cyc(10);
      chk("stop while off", 32'h0, 32'(stop));
   endtask

   task s_trip;
      apb(1'b1, `BFM_OFS_CTRL, 32'h1);
      stuck <= 4'h4;
      pulse(2);
      pulse(1);
      cyc(10);
      chk("stop good open", 32'h0, 32'(stop));
      apb(1'b0, `BFM_OFS_STATUS, 32'h0);
      chk("open decode", 32'hB, (q >> `BFM_ST_OPEN_LSB) & 32'hF);
      pulse(0);
      cyc(10);
      chk("stop good close", 32'h0, 32'(stop));
      stuck <= 4'h0;
   endtask

   task s_open_stuck;
      stuck <= 4'h2;
      pulse(1);
      cyc(5);
      chk("stop before tmo", 32'h0, 32'(stop));
      cyc(4);
      chk("stop open tmo", 32'h1, 32'(stop));
      apb(1'b0, `BFM_OFS_STATUS, 32'h0);
      chk("cause", 32'(`BFM_CAUSE_OPEN), (q >> `BFM_ST_CAUSE_LSB) & 32'h3);
      chk("culprit", 32'h2, (q >> `BFM_ST_CHG_LSB) & 32'hF);
      stuck <= 4'h0;
      pulse(0);
      cyc(10);
      chk("stop latched", 32'h1, 32'(stop));
      chk("nv out", 32'h1, 32'(nv_out));
      apb(1'b1, `BFM_OFS_CTRL, 32'h3);
      cyc(2);
      chk("stop unlocked", 32'h0, 32'(stop));
   endtask

   task s_drive_open;
      pulse(1);
      cyc(10);
      pulse(2);
      cyc(2);
      chk("stop drive open", 32'h1, 32'(stop));
      apb(1'b0, `BFM_OFS_STATUS, 32'h0);
      chk("drive cause", 32'(`BFM_CAUSE_DRIVE), (q >> `BFM_ST_CAUSE_LSB) & 32'h3);
      chk("drive culprit", 32'h3, (q >> `BFM_ST_CHG_LSB) & 32'hF);
      apb(1'b1, `BFM_OFS_CTRL, 32'h3);
      pulse(0);
      cyc(10);
      chk("stop after unlock", 32'h0, 32'(stop));
   endtask

   task s_close_stuck;
      pulse(1);
      cyc(10);
      stuck <= 4'h1;
      pulse(0);
      cyc(5);
      chk("stop before close tmo", 32'h0, 32'(stop));
      cyc(4);
      chk("stop close tmo", 32'h1, 32'(stop));
      apb(1'b0, `BFM_OFS_STATUS, 32'h0);
      chk("cause", 32'(`BFM_CAUSE_CLOSE), (q >> `BFM_ST_CAUSE_LSB) & 32'h3);
      stuck <= 4'h0;
   endtask

   task s_power_cycle;
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      nv_in <= 1'b1;
      cyc(12);
      i_rst_n <= 1'b1;
      cyc(3);
      chk("stop restored", 32'h1, 32'(stop));
      apb(1'b1, `BFM_OFS_CTRL, 32'h3);
      cyc(2);
      chk("stop cleared", 32'h0, 32'(stop));
   endtask

   // -------------------------
   // Main sequence and watchdog
   // -------------------------
   initial begin
      cyc(12);
      i_rst_n <= 1'b1;
      s_regs;
      s_disabled;
      s_trip;
      s_open_stuck;
      s_drive_open;
      s_close_stuck;
      s_power_cycle;
      report_and_stop;
   end

   initial begin
      #3000000;
      n_fail++;
      report_and_stop;
   end
endmodule
`default_nettype wire
